/* dv/sw_mask_model.sv */
/*
 Software side of the vector control write path: masks each raw value.
 Assumes the mask is the one read back from the saved image.
*/
`timescale 1ns/1ps
`default_nettype none
module sw_mask_model (
    // Reported mask and raw value
    input  wire logic [31:0] reported_mask,
    input  wire logic [31:0] raw_value,
    // Value to write
    output logic      [31:0] masked_value
);
    import fp_image_pkg::*;
    // Zero mask falls back to the default mask
    assign masked_value = raw_value
        & ((reported_mask == 32'h0) ? VMASK_DEFAULT : reported_mask);
endmodule // sw_mask_model
`default_nettype wire

/* dv/tb.sv */
/*
 Bench for fp_state_save_image: AXI4-Lite master tasks, image rows, faults.
 Assumes the design package and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fp_image_pkg::*;
    logic        core_clk, rst, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv, nm, gp;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat, tmp, mask, msk_val;
    logic [1:0]  bresp, rresp, r2;
    logic [3:0]  wstrb;
    logic [43:0] rows [8];
    int          miscompares, tests_run, nm_cnt, gp_cnt;
    fp_state_save_image fp_state_save_image_inst (.core_clk(core_clk), .rst(rst),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(wstrb), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .device_not_available_fault(nm), .general_protection_fault(gp));
    sw_mask_model sw_mask_model_inst (.reported_mask(mask), .raw_value(32'h0001ffc0),
        .masked_value(msk_val));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (nm === 1'b1) nm_cnt++;
    always @(posedge core_clk) if (gp === 1'b1) gp_cnt++;
    task automatic stop_test();
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(string nam, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nam, e, g);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [31:0] d);
        @(posedge core_clk);
        {awv, wv, br} <= 3'b111;
        awa <= a;
        wd <= d;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) break;
        end
        if (bv !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        r2 = bresp;
        br <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a);
        @(posedge core_clk);
        {arv, rr} <= 2'b11;
        ara <= a;
        for (int n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        if (rv !== 1'b1) begin
            miscompares++;
            stop_test();
        end
        tmp = rdat;
        r2 = rresp;
        rr <= 1'b0;
    endtask
    initial begin
        {rst, awv, wv, br, arv, rr, awa, ara, wd, wstrb} = {1'b1, 5'h0, 24'h0, 32'h0, 4'hf};
        rows = '{{12'h000, 32'h0000037f}, {12'h004, 32'h00000000}, {12'h008, 32'h0},
            {12'h018, 32'h00001f80}, {12'h01c, 32'h0000ffbf}, {12'h020, 32'h0},
            {12'h02c, 32'h0}, {12'h0a0, 32'h0}};
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        wr(12'h0a0, 32'hffffffff);
        wr(12'h02c, 32'hffffffff);
        wr(REG_CTRL, 32'h00000009);
        wr(REG_CTRL, 32'h00000049);
        foreach (rows[i]) begin
            rd(rows[i][43:32]);
            chk("image word", rows[i][31:0], tmp);
        end
        wr(12'h004, 32'h00000001);
        wr(REG_CTRL, 32'h00000089);
        rd(REG_STATUS);
        chk("rebuilt tags", 32'h0000fffd, tmp);
        rd(REG_VCSR_WR);
        chk("restored vcsr", 32'h00001f80, tmp);
        wr(12'h018, 32'h12345678);
        wr(REG_CTRL, 32'h00000008);
        wr(REG_CTRL, 32'h00000048);
        rd(12'h018);
        chk("vcsr kept", 32'h12345678, tmp);
        rd(12'h004);
        chk("tag byte", 32'h00000001, tmp);
        wr(12'h00c, 32'h00001234);
        wr(12'h010, 32'h0000abcd);
        wr(REG_CTRL, 32'h00000010);
        wr(REG_CTRL, 32'h00000090);
        wr(REG_CTRL, 32'h00000050);
        rd(12'h00c);
        chk("narrow selector", 32'h00001234, tmp);
        rd(12'h010);
        chk("no operand pointer", 32'h0, tmp);
        rd(12'h01c);
        mask = tmp;
        wr(REG_VCSR_WR, 32'h0001ffc0);
        rd(REG_FAULT);
        chk("gp fault", 32'h2, tmp);
        wr(REG_FAULT, 32'h3);
        wr(REG_VCSR_WR, msk_val);
        rd(REG_FAULT);
        chk("masked write", 32'h0, tmp);
        mask = 32'h0;
        #1 chk("default mask", 32'h0000ff80, msk_val);
        wr(REG_CTRL, 32'h2);
        wr(REG_EXEC, 32'h0);
        rd(REG_FAULT);
        chk("nm fault", 32'h1, tmp);
        wr(REG_FAULT, 32'h3);
        wr(REG_CTRL, 32'h0);
        wr(REG_EXEC, 32'h0);
        rd(REG_FAULT);
        chk("no nm", 32'h0, tmp);
        chk("nm pulses", 32'h1, nm_cnt);
        wr(REG_CTRL, 32'h20);
        rd(REG_CTRL);
        chk("legacy switch", 32'h2, tmp);
        wr(REG_CTRL, 32'h24);
        rd(REG_CTRL);
        chk("long switch", 32'h4, tmp);
        wr(12'h214, 32'h0);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r2});
        rd(12'h214);
        chk("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r2});
        chk("gp pulses", 32'h1, gp_cnt);
        stop_test();
    end
endmodule // tb
`default_nettype wire

/* hdl/fp_image_pkg.sv */
/*
 Package for the compact floating-point/vector state save image block:
 image byte offsets, field widths, register offsets of the AXI4-Lite map.
 Assumes a 32-bit AXI4-Lite register bus and a single core clock.
*/
package fp_image_pkg;
    localparam int unsigned DATA_W          = 32;
    localparam int unsigned ADDR_W          = 12;
    // Image byte offsets
    localparam logic [11:0] OFF_CTRL_WORD   = 12'h000;
    localparam logic [11:0] OFF_STATUS_WORD = 12'h002;
    localparam logic [11:0] OFF_TAG         = 12'h004;
    localparam logic [11:0] OFF_TAG_PAD     = 12'h005;
    localparam logic [11:0] OFF_OPCODE      = 12'h006;
    localparam logic [11:0] OFF_IPTR        = 12'h008;
    localparam logic [11:0] OFF_CSEL        = 12'h00c;
    localparam logic [11:0] OFF_DPTR        = 12'h010;
    localparam logic [11:0] OFF_DSEL        = 12'h014;
    localparam logic [11:0] OFF_VCSR        = 12'h018;
    localparam logic [11:0] OFF_VMASK       = 12'h01c;
    localparam logic [11:0] OFF_STACK       = 12'h020;
    localparam logic [11:0] OFF_STACK_END   = 12'h09f;
    localparam logic [11:0] OFF_VREG        = 12'h0a0;
    localparam logic [11:0] OFF_VREG_END    = 12'h11f;
    localparam logic [11:0] IMAGE_END       = 12'h1ff;
    localparam logic [11:0] SLOT_BYTES      = 12'h010;
    // Control registers, beyond the image window
    localparam logic [11:0] REG_CTRL        = 12'h200;
    localparam logic [11:0] REG_STATUS      = 12'h204;
    localparam logic [11:0] REG_VCSR_WR     = 12'h208;
    localparam logic [11:0] REG_EXEC        = 12'h20c;
    localparam logic [11:0] REG_FAULT       = 12'h210;
    // Control register bits
    localparam int unsigned CTRL_OSVEC      = 0;
    localparam int unsigned CTRL_TS         = 1;
    localparam int unsigned CTRL_LONG       = 2;
    localparam int unsigned CTRL_WIDE       = 3;
    localparam int unsigned CTRL_NOMEM      = 4;
    localparam int unsigned CTRL_TSWITCH    = 5;
    localparam int unsigned CTRL_SAVE       = 6;
    localparam int unsigned CTRL_RESTORE    = 7;
    localparam int unsigned FAULT_NM        = 0;
    localparam int unsigned FAULT_GP        = 1;
    localparam int unsigned DAZ_BIT         = 6;
    localparam logic [31:0] VMASK_DEFAULT   = 32'h0000_ffbf;
    localparam logic [31:0] VCSR_RESET      = 32'h0000_1f80;
    localparam logic [15:0] CTRL_WORD_RESET = 16'h037f;
    localparam logic [1:0]  TAG_VALID       = 2'b00;
    localparam logic [1:0]  TAG_ZERO        = 2'b01;
    localparam logic [1:0]  TAG_SPECIAL     = 2'b10;
    localparam logic [1:0]  TAG_EMPTY       = 2'b11;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;
endpackage

/* hdl/fp_state_save_image.sv */
/*
 Compact save image engine for floating-point and vector state, reached
 over AXI4-Lite. Image words sit at 000h-1ffh; control at 200h-210h, SLVERR above.
 Assumes one clock, synchronous reset and software as the only partner.
*/
// Chosen here: the register offsets and register access over AXI4-Lite.
// Overview of operation
// [R1] Control word at bytes 0-1, status word at bytes 2-3.
// [R2] Compressed tag byte at offset 4; offset 5 always zero.
// [R3] Last opcode stored at bytes 6 and 7.
// [R4] Instruction pointer from byte 8: 64-bit offset, or 32-bit plus selector.
// [R5] Data pointer from byte 16: 64-bit offset, or 32-bit plus selector.
// [R6] Data pointer may hold any value when no memory operand.
// [R7] Vector control/status saved at 18h only when OS enable set.
// [R8] Support mask at 1Ch; ones are supported bits, bit 6 is denormals-zero.
// [R9] Writing a reserved vector control bit raises general protection fault.
// [R10] Software uses default mask if the reported mask is zero.
// [R11] Software ANDs a non-zero mask into every control write.
// [R12] Eight stack registers at 20h-9Fh, sixteen bytes each, top six reserved.
// [R13] Vector registers saved at A0h-11Fh only when OS enable set.
// [R14] Tags 00, 01, 10 compress to 1; tag 11 to 0.
// [R15] Tag rebuild: empty 11, zero 01, normal 00, else 10.
// [R16] Task-switched flag set makes any media or fp instruction fault.
// [R17] Fault handler clears task-switched flag before returning.
// [R18] Legacy mode hardware task switch sets the task-switched flag.
// [R19] Long mode never sets the task-switched flag by itself.
// [R20] Restore reverses the layout, loading vector fields only when enabled.
`timescale 1ns/1ps
`default_nettype none
module fp_state_save_image
    import fp_image_pkg::*;
#(
    parameter logic [31:0] SUPPORT_MASK = VMASK_DEFAULT
)(
    // Clock and reset
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    // AXI4-Lite write address and data
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [fp_image_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    input  wire logic [fp_image_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    // AXI4-Lite write response
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    output logic      [1:0]                      s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    input  wire logic [fp_image_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    output logic      [fp_image_pkg::DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]                      s_axi_rresp,
    // Fault pulses
    output logic                                 device_not_available_fault,
    output logic                                 general_protection_fault
);
    import fp_image_pkg::*;

    // Live state
    logic [15:0]  fp_control_word;
    logic [15:0]  fp_status_word;
    logic [15:0]  fp_tag_word;
    logic [15:0]  last_fp_opcode;
    logic [63:0]  instr_ptr_wide;
    logic [15:0]  code_selector;
    logic [63:0]  data_ptr_wide;
    logic [15:0]  data_selector;
    logic [31:0]  vector_ctrl_status;
    logic [79:0]  fp_stack_reg [8];
    logic [127:0] vector_reg_128 [8];
    // Memory image, one 32-bit word per entry
    logic [31:0]  image_mem [128];
    logic [7:0]   ctrl_reg;
    logic         task_switched_flag;
    logic [1:0]   fault_sticky_reg;
    logic         os_vector_state_enable;
    logic [7:0]   short_tags;
    logic [7:0]   restored_short;
    logic [1:0]   rebuilt_tag [8];
    logic [31:0]  save_word [128];

    assign os_vector_state_enable = ctrl_reg[CTRL_OSVEC];

    // Save image word assembly
    always_comb begin
        for (int w = 0; w < 128; w++) begin
            save_word[w] = image_mem[w];
        end
        save_word[OFF_CTRL_WORD[8:2]] = {fp_status_word, fp_control_word}; // R1
        save_word[OFF_TAG[8:2]] = {last_fp_opcode, 8'h00, short_tags}; // R2 R3
        if (ctrl_reg[CTRL_WIDE]) begin
            save_word[OFF_IPTR[8:2]]     = instr_ptr_wide[31:0]; // R4
            save_word[OFF_IPTR[8:2] + 1] = instr_ptr_wide[63:32]; // R4
            save_word[OFF_DPTR[8:2]]     = data_ptr_wide[31:0]; // R5
            save_word[OFF_DPTR[8:2] + 1] = data_ptr_wide[63:32]; // R5
        end else begin
            save_word[OFF_IPTR[8:2]]     = instr_ptr_wide[31:0]; // R4
            save_word[OFF_CSEL[8:2]]     = {16'h0000, code_selector}; // R4
            save_word[OFF_DPTR[8:2]]     = data_ptr_wide[31:0]; // R5
            save_word[OFF_DSEL[8:2]]     = {16'h0000, data_selector}; // R5
        end
        if (ctrl_reg[CTRL_NOMEM]) begin
            save_word[OFF_DPTR[8:2]] = 32'h0000_0000; // R6
        end
        if (os_vector_state_enable) begin
            save_word[OFF_VCSR[8:2]] = vector_ctrl_status; // R7
        end
        save_word[OFF_VMASK[8:2]] = SUPPORT_MASK; // R8
        for (int r = 0; r < 8; r++) begin
            save_word[OFF_STACK[8:2] + 4*r]     = fp_stack_reg[r][31:0]; // R12
            save_word[OFF_STACK[8:2] + 4*r + 1] = fp_stack_reg[r][63:32]; // R12
            save_word[OFF_STACK[8:2] + 4*r + 2] = {16'h0000, fp_stack_reg[r][79:64]}; // R12
            save_word[OFF_STACK[8:2] + 4*r + 3] = 32'h0000_0000; // R12
            if (os_vector_state_enable) begin
                for (int k = 0; k < 4; k++) begin
                    save_word[OFF_VREG[8:2] + 4*r + k] = vector_reg_128[r][32*k +: 32]; // R13
                end
            end
        end
    end

    tag_codec u_tag_codec (
        .full_tags   (fp_tag_word),
        .short_tags  (short_tags),
        .short_bit   (1'b1),
        .value       (fp_stack_reg[0]),
        .rebuilt_tag ()
    );

    // Rebuild full tags from the image on restore
    assign restored_short = image_mem[OFF_TAG[8:2]][7:0];
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rebuild
            tag_codec u_rebuild (
                .full_tags   (16'h0000),
                .short_tags  (),
                .short_bit   (restored_short[g]),
                .value       ({image_mem[OFF_STACK[8:2] + 4*g + 2][15:0],
                               image_mem[OFF_STACK[8:2] + 4*g + 1],
                               image_mem[OFF_STACK[8:2] + 4*g]}),
                .rebuilt_tag (rebuilt_tag[g])
            );
        end
    endgenerate

    // AXI4-Lite write channel
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_go;
    logic [31:0] strobe_mask;

    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign strobe_mask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
                          {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= '0;
            w_strb_reg    <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg > REG_FAULT) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_image;
    logic wr_ctrl;
    logic wr_vcsr;
    logic wr_exec;
    logic wr_fault;
    logic [31:0] wr_merge_ctrl;
    assign wr_image = wr_go && (aw_addr_reg <= IMAGE_END);
    assign wr_ctrl  = wr_go && (aw_addr_reg[11:2] == REG_CTRL[11:2]);
    assign wr_vcsr  = wr_go && (aw_addr_reg[11:2] == REG_VCSR_WR[11:2]);
    assign wr_exec  = wr_go && (aw_addr_reg[11:2] == REG_EXEC[11:2]);
    assign wr_fault = wr_go && (aw_addr_reg[11:2] == REG_FAULT[11:2]);
    assign wr_merge_ctrl = ({24'h0, ctrl_reg} & ~strobe_mask) | (w_data_reg & strobe_mask);

    // Image memory: software writes and save commands
    always_ff @(posedge core_clk) begin
        if (wr_ctrl && wr_merge_ctrl[CTRL_SAVE]) begin
            for (int w = 0; w < 128; w++) begin
                image_mem[w] <= save_word[w];
            end
        end else if (wr_image) begin
            image_mem[aw_addr_reg[8:2]] <= (image_mem[aw_addr_reg[8:2]] & ~strobe_mask)
                                           | (w_data_reg & strobe_mask);
        end
    end

    // Control register and task-switched flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_reg           <= '0;
            task_switched_flag <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= wr_merge_ctrl[7:0] & 8'h1f;
                task_switched_flag <= wr_merge_ctrl[CTRL_TS]; // R19
                if (wr_merge_ctrl[CTRL_TSWITCH] && !wr_merge_ctrl[CTRL_LONG]) begin
                    task_switched_flag <= 1'b1; // R18
                end
            end
        end
    end

    // Live state load: vector control writes and restores
    logic vcsr_bad;
    logic do_restore;
    assign vcsr_bad   = |(w_data_reg & ~SUPPORT_MASK);
    assign do_restore = wr_ctrl && wr_merge_ctrl[CTRL_RESTORE];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fp_control_word    <= CTRL_WORD_RESET;
            fp_status_word     <= '0;
            fp_tag_word        <= '1;
            last_fp_opcode     <= '0;
            instr_ptr_wide     <= '0;
            code_selector      <= '0;
            data_ptr_wide      <= '0;
            data_selector      <= '0;
            vector_ctrl_status <= VCSR_RESET;
            for (int r = 0; r < 8; r++) begin
                fp_stack_reg[r]   <= '0;
                vector_reg_128[r] <= '0;
            end
        end else if (do_restore) begin
            {fp_status_word, fp_control_word} <= image_mem[OFF_CTRL_WORD[8:2]]; // R20
            last_fp_opcode <= image_mem[OFF_OPCODE[8:2]][31:16]; // R20
            instr_ptr_wide[31:0] <= image_mem[OFF_IPTR[8:2]]; // R20
            data_ptr_wide[31:0]  <= image_mem[OFF_DPTR[8:2]]; // R20
            if (ctrl_reg[CTRL_WIDE]) begin
                instr_ptr_wide[63:32] <= image_mem[OFF_IPTR[8:2] + 1]; // R20
                data_ptr_wide[63:32]  <= image_mem[OFF_DPTR[8:2] + 1]; // R20
            end else begin
                code_selector <= image_mem[OFF_CSEL[8:2]][15:0]; // R20
                data_selector <= image_mem[OFF_DSEL[8:2]][15:0]; // R20
            end
            for (int r = 0; r < 8; r++) begin
                fp_tag_word[2*r +: 2] <= rebuilt_tag[r]; // R15
                fp_stack_reg[r] <= {image_mem[OFF_STACK[8:2] + 4*r + 2][15:0],
                                    image_mem[OFF_STACK[8:2] + 4*r + 1],
                                    image_mem[OFF_STACK[8:2] + 4*r]}; // R20
                if (os_vector_state_enable) begin
                    for (int k = 0; k < 4; k++) begin
                        vector_reg_128[r][32*k +: 32] <= image_mem[OFF_VREG[8:2] + 4*r + k]; // R20
                    end
                end
            end
            if (os_vector_state_enable) begin
                vector_ctrl_status <= image_mem[OFF_VCSR[8:2]] & SUPPORT_MASK; // R20
            end
        end else if (wr_vcsr && !vcsr_bad) begin
            vector_ctrl_status <= w_data_reg; // R9
        end
    end

    // Faults: pulses plus sticky status, set wins over clear
    logic nm_event;
    logic gp_event;
    assign nm_event = wr_exec && task_switched_flag; // R16
    assign gp_event = wr_vcsr && vcsr_bad; // R9

    always_ff @(posedge core_clk) begin
        if (rst) begin
            device_not_available_fault <= 1'b0;
            general_protection_fault   <= 1'b0;
            fault_sticky_reg           <= '0;
        end else begin
            device_not_available_fault <= nm_event; // R16
            general_protection_fault   <= gp_event; // R9
            fault_sticky_reg <= (fault_sticky_reg & ~(wr_fault ? w_data_reg[1:0] : 2'b00))
                                | {gp_event, nm_event};
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                if (s_axi_araddr <= IMAGE_END) begin
                    s_axi_rdata <= image_mem[s_axi_araddr[8:2]];
                end else if (s_axi_araddr[11:2] == REG_CTRL[11:2]) begin
                    s_axi_rdata <= {24'h0, ctrl_reg[7:2], task_switched_flag, ctrl_reg[0]};
                end else if (s_axi_araddr[11:2] == REG_STATUS[11:2]) begin
                    s_axi_rdata <= {16'h0, fp_tag_word};
                end else if (s_axi_araddr[11:2] == REG_VCSR_WR[11:2]) begin
                    s_axi_rdata <= vector_ctrl_status;
                end else if (s_axi_araddr[11:2] == REG_FAULT[11:2]) begin
                    s_axi_rdata <= {30'h0, fault_sticky_reg};
                end else begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= (s_axi_araddr[11:2] == REG_EXEC[11:2])
                                   ? RESP_OKAY : RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    property p_nm_fault;
        @(posedge core_clk) disable iff (rst)
        (wr_exec && task_switched_flag) |=> device_not_available_fault;
    endproperty
    a_nm_fault: assert property (p_nm_fault) else $error("missing not-available fault"); // R16

    property p_no_nm_clear;
        @(posedge core_clk) disable iff (rst)
        (wr_exec && !task_switched_flag) |=> !device_not_available_fault;
    endproperty
    a_no_nm_clear: assert property (p_no_nm_clear) else $error("spurious fault"); // R16

    property p_gp_fault;
        @(posedge core_clk) disable iff (rst)
        (wr_vcsr && |(w_data_reg & ~SUPPORT_MASK))
            |=> general_protection_fault && $stable(vector_ctrl_status);
    endproperty
    a_gp_fault: assert property (p_gp_fault) else $error("reserved bit accepted"); // R9

    property p_pad_zero;
        @(posedge core_clk) disable iff (rst)
        (wr_ctrl && wr_merge_ctrl[CTRL_SAVE])
            |=> image_mem[OFF_TAG_PAD[8:2]][15:8] == 8'h00
                && image_mem[OFF_VMASK[8:2]] == SUPPORT_MASK;
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("pad or mask wrong"); // R2

    property p_tag_compress;
        @(posedge core_clk) disable iff (rst)
        (wr_ctrl && wr_merge_ctrl[CTRL_SAVE])
            |=> image_mem[OFF_TAG[8:2]][0] == ($past(fp_tag_word[1:0]) != TAG_EMPTY);
    endproperty
    a_tag_compress: assert property (p_tag_compress) else $error("tag bit wrong"); // R14

    property p_ctrl_word;
        @(posedge core_clk) disable iff (rst)
        (wr_ctrl && wr_merge_ctrl[CTRL_SAVE])
            |=> image_mem[OFF_CTRL_WORD[8:2]]
                == {$past(fp_status_word), $past(fp_control_word)};
    endproperty
    a_ctrl_word: assert property (p_ctrl_word) else $error("control word misplaced"); // R1

    property p_long_ts;
        @(posedge core_clk) disable iff (rst)
        (!wr_ctrl) |=> $stable(task_switched_flag);
    endproperty
    a_long_ts: assert property (p_long_ts) else $error("flag changed by itself"); // R19

    property p_legacy_ts;
        @(posedge core_clk) disable iff (rst)
        (wr_ctrl && wr_merge_ctrl[CTRL_TSWITCH] && !wr_merge_ctrl[CTRL_LONG])
            |=> task_switched_flag;
    endproperty
    a_legacy_ts: assert property (p_legacy_ts) else $error("task switch left flag clear"); // R18
endmodule // fp_state_save_image
`default_nettype wire

/* hdl/tag_codec.sv */
/*
 Tag word codec: compresses the two-bit tags to one bit per register and
 rebuilds a two-bit tag from a full bit and the 80-bit register contents.
 Purely combinational; assumes the caller registers the results.
*/
`timescale 1ns/1ps
`default_nettype none
module tag_codec
    import fp_image_pkg::*;
(
    // Compression
    input  wire logic [15:0] full_tags,
    output logic      [7:0]  short_tags,
    // Rebuild of one tag
    input  wire logic        short_bit,
    input  wire logic [79:0] value,
    output logic      [1:0]  rebuilt_tag
);
    logic [14:0] expo;
    logic        int_bit;
    logic [62:0] frac;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_tag
            assign short_tags[g] = (full_tags[2*g +: 2] != TAG_EMPTY); // R14
        end
    endgenerate

    assign expo    = value[78:64];
    assign int_bit = value[63];
    assign frac    = value[62:0];

    always_comb begin
        if (!short_bit) begin
            rebuilt_tag = TAG_EMPTY; // R15
        end else if (expo == '0 && !int_bit && frac == '0) begin
            rebuilt_tag = TAG_ZERO; // R15
        end else if (expo != '0 && expo != '1 && int_bit) begin
            rebuilt_tag = TAG_VALID; // R15
        end else begin
            rebuilt_tag = TAG_SPECIAL; // R15
        end
    end
endmodule // tag_codec
`default_nettype wire
